// ===== hw/sac_adc_ctrl.sv
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
// How it works
// - ten-bit result found by successive approximation, one bit each bit_period
// - result sits right aligned; unused high result bits read zero
// - every source goes through one multiplexer into one sample-and-hold
// - five-bit channel_select_field in converter_control_first picks the mux input
// - 19 sources on the small variant, 22 on the large one
// - conversion_clock_select picks core clock /8, /16, /32, /64 or rc clock
// - dedicated_rc_clock is the internal oscillator divided by sixteen
// - a conversion takes exactly eleven bit periods
// - non-rc sources follow the core clock frequency
// - at the end: clear trigger, set done flag, load result pair
// - trigger cleared mid-conversion keeps old result, restart after two ticks
// - trigger set while converter_power is set and the sequencer is idle starts a conversion
// - done flag set at every completion regardless of mask; software clears it
module sac_adc_ctrl
  import sac_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1  // 1 selects the 22-source variant
) (
  input  wire logic        core_clk,   // system clock, 50 MHz
  input  wire logic        rst_b,      // async reset, active low
  input  wire logic [7:0]  paddr,      // apb byte address
  input  wire logic        psel,       // apb select
  input  wire logic        penable,    // apb access phase
  input  wire logic        pwrite,     // apb direction, high writes
  input  wire logic [31:0] pwdata,     // apb write data
  output logic      [31:0] prdata,     // apb read data
  output logic             pready,     // apb ready
  output logic             pslverr,    // apb error on unmapped address
  input  wire logic        osc_tick,   // internal oscillator pulse
  input  wire logic        cmp_above,  // held input at or above dac_code
  output logic      [4:0]  mux_select, // multiplexer input in use
  output logic             mux_valid,  // selected code names a real source
  output logic             hold_en,    // sample-and-hold disconnected and holding
  output logic      [9:0]  dac_code,   // trial code for the comparator
  output logic             adc_irq     // level interrupt
);

  sac_tick_if tk ();

  sac_state_t  state_reg;
  sac_state_t  state_next;
  logic [7:0]  ctrl_first_reg;
  logic [7:0]  ctrl_second_reg;
  logic [9:0]  result_reg;
  logic [9:0]  sar_reg;
  logic [9:0]  mask_reg;
  logic [3:0]  bit_cnt_reg;
  logic [1:0]  abort_cnt_reg;
  logic        status_reg;
  logic        int_mask_reg;
  logic [31:0] prdata_reg;
  logic        setup;
  logic        access;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic        wr_first;
  logic        go_wr1;
  logic        go_wr0;
  logic        power;
  logic        go;
  logic        tick;
  logic        done_evt;
  logic [6:0]  gap_reg;

  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign wr       = access && pwrite;
  assign rd       = access && !pwrite;
  assign wr_first = wr && (paddr == SAC_OFS_CTRL_FIRST);
  assign go_wr1   = wr_first && pwdata[SAC_GO_BIT];
  assign go_wr0   = wr_first && !pwdata[SAC_GO_BIT];
  assign power    = ctrl_first_reg[SAC_POWER_BIT];
  assign go       = ctrl_first_reg[SAC_GO_BIT];
  assign tick     = tk.tick;
  assign done_evt = (state_reg == SAC_DONE);

  // address decode
  always_comb begin
    case (paddr)
      SAC_OFS_CTRL_FIRST, SAC_OFS_CTRL_SECOND, SAC_OFS_RESULT_LOW,
      SAC_OFS_RESULT_HIGH, SAC_OFS_INT_STATUS, SAC_OFS_INT_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // zero wait state slave
  assign pready  = access;
  assign pslverr = access && !mapped;
  assign prdata  = prdata_reg;

  // read data captured in the setup cycle, result right aligned
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        SAC_OFS_CTRL_FIRST:  prdata_reg <= {24'h00_0000, ctrl_first_reg};
        SAC_OFS_CTRL_SECOND: prdata_reg <= {24'h00_0000, ctrl_second_reg};
        SAC_OFS_RESULT_LOW:  prdata_reg <= {24'h00_0000, result_reg[7:0]};
        SAC_OFS_RESULT_HIGH: prdata_reg <= {30'h0000_0000, result_reg[9:8]};
        SAC_OFS_INT_STATUS:  prdata_reg <= {31'h0000_0000, status_reg};
        SAC_OFS_INT_MASK:    prdata_reg <= {31'h0000_0000, int_mask_reg};
        default:             prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // converter_control_first: power, trigger and channel field
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_first_reg <= SAC_CTRL_FIRST_RST;
    end else if (wr_first) begin
      ctrl_first_reg[SAC_POWER_BIT] <= pwdata[SAC_POWER_BIT];
      // channel field takes effect at once, busy or not
      ctrl_first_reg[SAC_CHS_LSB +: SAC_CHS_W] <= pwdata[SAC_CHS_LSB +: SAC_CHS_W];
      // trigger sets only while powered and idle clearing aborts
      if (go_wr1) begin
        ctrl_first_reg[SAC_GO_BIT] <= go || (pwdata[SAC_POWER_BIT] && power &&
                                             state_reg == SAC_IDLE);
      end else begin
        ctrl_first_reg[SAC_GO_BIT] <= 1'b0;
      end
    end else if (done_evt) begin
      ctrl_first_reg[SAC_GO_BIT] <= 1'b0;
    end else if (!power) begin
      ctrl_first_reg[SAC_GO_BIT] <= 1'b0;
    end
  end

  // converter_control_second and interrupt mask
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_second_reg <= SAC_CTRL_SECOND_RST;
      int_mask_reg    <= 1'b0;
    end else if (wr && paddr == SAC_OFS_CTRL_SECOND) begin
      ctrl_second_reg <= {1'b0, pwdata[SAC_CLKSEL_LSB +: SAC_CLKSEL_W], 4'h0};
    end else if (wr && paddr == SAC_OFS_INT_MASK) begin
      int_mask_reg <= pwdata[SAC_DONE_BIT];
    end
  end

  // done flag: set at every completion, read clears what was returned
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= 1'b0;
    end else if (done_evt) begin
      status_reg <= 1'b1; // set wins over a clearing read
    end else if (rd && paddr == SAC_OFS_INT_STATUS && prdata_reg[SAC_DONE_BIT]) begin
      status_reg <= 1'b0;
    end
  end

  assign adc_irq = status_reg && int_mask_reg;

  // conversion clock source request
  assign tk.clk_sel = ctrl_second_reg[SAC_CLKSEL_LSB +: SAC_CLKSEL_W];
  assign tk.restart = (state_reg == SAC_IDLE) && go;

  sac_tick_gen u_tick (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .osc_tick (osc_tick),
    .tk       (tk)
  );

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SAC_IDLE: begin
        if (go) state_next = SAC_CONV;
      end
      SAC_CONV: begin
        if (!go) state_next = SAC_ABORT;
        else if (tick && bit_cnt_reg == SAC_LAST_BIT) state_next = SAC_DONE;
      end
      SAC_DONE:  state_next = SAC_IDLE;
      SAC_ABORT: begin
        if (tick && abort_cnt_reg == SAC_ABORT_TICKS - 2'h1) state_next = SAC_IDLE;
      end
      default:   state_next = SAC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) state_reg <= SAC_IDLE;
    else        state_reg <= state_next;
  end

  // bit period and abort delay counters
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_reg   <= 4'h0;
      abort_cnt_reg <= 2'h0;
    end else begin
      if (state_reg != SAC_CONV) bit_cnt_reg <= 4'h0;
      else if (tick)             bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (state_reg != SAC_ABORT) abort_cnt_reg <= 2'h0;
      else if (tick)              abort_cnt_reg <= abort_cnt_reg + 2'h1;
    end
  end

  // successive approximation, msb first, one bit per tick after sampling
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sar_reg  <= 10'h000;
      mask_reg <= 10'h000;
    end else if (state_reg == SAC_IDLE) begin
      sar_reg  <= 10'h000;
      mask_reg <= SAC_MSB_TRIAL;
    end else if (state_reg == SAC_CONV && tick && bit_cnt_reg != 4'h0) begin
      if (!cmp_above) sar_reg <= sar_reg & ~mask_reg;
      else            sar_reg <= sar_reg | mask_reg;
      mask_reg <= mask_reg >> 1;
    end
  end

  // result pair loads only on completion abort keeps old value
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)        result_reg <= SAC_RESULT_RST;
    else if (done_evt) result_reg <= sar_reg;
  end

  // analog side: one mux into one hold stage
  assign mux_select = ctrl_first_reg[SAC_CHS_LSB +: SAC_CHS_W];
  assign hold_en    = (state_reg == SAC_CONV);
  assign dac_code   = sar_reg | mask_reg;

  // source presence per variant; reserved codes only flag, nothing else
  always_comb begin
    mux_valid = (mux_select <= SAC_CH_LAST) && (mux_select != SAC_CH_RSVD_A) &&
                (mux_select != SAC_CH_RSVD_B);
    if (!LARGE_VARIANT && mux_select >= SAC_CH_EXT_HI_FIRST &&
        mux_select <= SAC_CH_EXT_HI_LAST) mux_valid = 1'b0;
  end

  // core cycles since the last bit period tick, kept for the period checks
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_reg <= 7'h00;
    end else if (tick || tk.restart) begin
      gap_reg <= 7'h00;
    end else if (gap_reg != 7'h7f) begin
      gap_reg <= gap_reg + 7'h01;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_done_sets_flag: assert property (done_evt |=> status_reg)
    else $error("done flag not set after completion");
  a_done_clears_go: assert property (done_evt |=> !go && state_reg == SAC_IDLE)
    else $error("trigger not cleared after completion");
  a_done_loads_res: assert property (done_evt |=> result_reg == $past(sar_reg))
    else $error("result not loaded on completion");
  a_abort_keeps_res: assert property (state_reg == SAC_ABORT |=> $stable(result_reg))
    else $error("result changed during abort");
  a_abort_two_ticks: assert property (state_reg == SAC_ABORT && tick &&
                                      abort_cnt_reg == 2'h0 |=> state_reg == SAC_ABORT)
    else $error("abort left before two conversion clocks");
  a_start_needs_pow: assert property (state_reg == SAC_IDLE ##1 state_reg == SAC_CONV
                                      |-> $past(power, 2))
    else $error("conversion started without power");
  a_eleven_periods: assert property ($rose(done_evt) |-> $past(bit_cnt_reg) == 4'ha)
    else $error("conversion not eleven bit periods");
  a_mux_switch_now: assert property (wr_first |=>
                                     mux_select == $past(pwdata[SAC_CHS_LSB +: SAC_CHS_W]))
    else $error("mux did not follow channel field");
  a_right_justify: assert property (rd && paddr == SAC_OFS_RESULT_HIGH
                                    |-> prdata[31:2] == 30'h0000_0000)
    else $error("high result byte not right justified");
  a_div16_period: assert property (tick && bit_cnt_reg != 4'h0 &&
                                   state_reg == SAC_CONV && tk.clk_sel == SAC_CLK_DIV16
                                   |-> gap_reg == {1'b0, SAC_TC_DIV16})
    else $error("bit period not sixteen core cycles");
  a_tick_single: assert property (tick |=> !tick)
    else $error("bit period tick longer than one cycle");
  a_first_trial: assert property (state_reg == SAC_CONV &&
                                  $past(state_reg) == SAC_IDLE |-> dac_code == SAC_MSB_TRIAL)
    else $error("first trial is not the msb");
  a_abort_no_flag: assert property (state_reg == SAC_ABORT |=> !$rose(status_reg))
    else $error("abort set the done flag");
  a_clear_aborts: assert property (state_reg == SAC_CONV && !go
                                   |=> state_reg == SAC_ABORT)
    else $error("cleared trigger did not abort");
  a_status_clears: assert property (rd && paddr == SAC_OFS_INT_STATUS &&
                                    prdata[SAC_DONE_BIT] && !done_evt |=> !status_reg)
    else $error("reading the done flag did not clear it");
  a_res_only_done: assert property (!done_evt |=> $stable(result_reg))
    else $error("result changed without a completion");
  a_refuse_unpow: assert property (go_wr1 && !power && !go |=> !go)
    else $error("trigger accepted while unpowered");

  c_conv_done:   cover property (state_reg == SAC_CONV ##[1:800] done_evt);
  c_conv_abort:  cover property (state_reg == SAC_CONV ##1 state_reg == SAC_ABORT);
  c_status_read: cover property (status_reg && rd && paddr == SAC_OFS_INT_STATUS);
  c_rc_done:     cover property (done_evt && tk.clk_sel[1:0] == SAC_CLK_RC_LO);
  c_chan_switch: cover property (hold_en && wr_first);

endmodule

// ===== hw/sac_pkg.sv
package sac_pkg;

  // register byte offsets
  localparam logic [7:0] SAC_OFS_CTRL_FIRST  = 8'h00; // converter_control_first
  localparam logic [7:0] SAC_OFS_CTRL_SECOND = 8'h04; // converter_control_second
  localparam logic [7:0] SAC_OFS_RESULT_LOW  = 8'h08; // result_low_byte
  localparam logic [7:0] SAC_OFS_RESULT_HIGH = 8'h0c; // result_high_byte
  localparam logic [7:0] SAC_OFS_INT_STATUS  = 8'h10; // sticky event bits, read clears
  localparam logic [7:0] SAC_OFS_INT_MASK    = 8'h14; // interrupt mask

  // converter_control_first fields
  localparam int SAC_POWER_BIT   = 0; // converter_power
  localparam int SAC_GO_BIT      = 1; // conversion trigger, busy while high
  localparam int SAC_CHS_LSB     = 2; // channel_select_field lsb
  localparam int SAC_CHS_W       = 5;
  // converter_control_second fields
  localparam int SAC_CLKSEL_LSB  = 4; // conversion_clock_select lsb
  localparam int SAC_CLKSEL_W    = 3;
  // status / mask fields
  localparam int SAC_DONE_BIT    = 0; // conversion_done_flag

  localparam int SAC_RES_W       = 10;
  localparam int SAC_BYTE_W      = 8;

  // reset values
  localparam logic [7:0] SAC_CTRL_FIRST_RST  = 8'h00;
  localparam logic [7:0] SAC_CTRL_SECOND_RST = 8'h00;
  localparam logic [9:0] SAC_RESULT_RST      = 10'h000;

  // conversion_clock_select encodings
  localparam logic [2:0] SAC_CLK_DIV8  = 3'h1;
  localparam logic [2:0] SAC_CLK_DIV16 = 3'h5;
  localparam logic [2:0] SAC_CLK_DIV32 = 3'h2;
  localparam logic [2:0] SAC_CLK_DIV64 = 3'h6;
  localparam logic [1:0] SAC_CLK_RC_LO = 2'h3; // x11 selects dedicated_rc_clock

  // terminal counts (divisor minus one)
  localparam logic [5:0] SAC_TC_DIV8  = 6'h07;
  localparam logic [5:0] SAC_TC_DIV16 = 6'h0f;
  localparam logic [5:0] SAC_TC_DIV32 = 6'h1f;
  localparam logic [5:0] SAC_TC_DIV64 = 6'h3f;
  localparam logic [3:0] SAC_TC_RC    = 4'hf;  // internal oscillator divided by 16

  // bit periods per conversion: one sampling period plus ten bits
  localparam int         SAC_PERIODS   = 11;
  localparam logic [3:0] SAC_LAST_BIT  = 4'ha;
  localparam logic [1:0] SAC_ABORT_TICKS = 2'h2;
  localparam logic [9:0] SAC_MSB_TRIAL = 10'h200;

  // channel map
  localparam logic [4:0] SAC_CH_EXT_HI_FIRST = 5'h05; // extra pins, larger variant only
  localparam logic [4:0] SAC_CH_EXT_HI_LAST  = 5'h07;
  localparam logic [4:0] SAC_CH_RSVD_A       = 5'h10;
  localparam logic [4:0] SAC_CH_RSVD_B       = 5'h11;
  localparam logic [4:0] SAC_CH_LAST         = 5'h17;

  typedef enum logic [1:0] {
    SAC_IDLE  = 2'b00,
    SAC_CONV  = 2'b01,
    SAC_DONE  = 2'b11,
    SAC_ABORT = 2'b10
  } sac_state_t;

endpackage

// ===== hw/sac_tick_if.sv
`timescale 1ns/1ns
// conversion clock request and bit period tick between controller and divider
interface sac_tick_if;
  logic [2:0] clk_sel; // conversion_clock_select
  logic       restart; // realign divider to a conversion start
  logic       tick;    // one core cycle per bit_period

  modport ctrl (output clk_sel, output restart, input tick);
  modport gen  (input clk_sel, input restart, output tick);
endinterface

// ===== hw/sac_tick_gen.sv
`timescale 1ns/1ns
module sac_tick_gen
  import sac_pkg::*;
(
  input  wire logic core_clk,  // system clock
  input  wire logic rst_b,     // async reset, active low
  input  wire logic osc_tick,  // one pulse per internal oscillator cycle
  sac_tick_if.gen   tk         // tick request and answer
);

  logic [5:0] sys_cnt_reg;
  logic [3:0] rc_cnt_reg;
  logic [5:0] sys_tc;
  logic       use_rc;
  logic       sys_hit;
  logic       rc_hit;
  logic       tick_reg;

  // pick the terminal count for the system clock dividers
  always_comb begin
    use_rc = (tk.clk_sel[1:0] == SAC_CLK_RC_LO);
    case (tk.clk_sel)
      SAC_CLK_DIV8:  sys_tc = SAC_TC_DIV8;
      SAC_CLK_DIV16: sys_tc = SAC_TC_DIV16;
      SAC_CLK_DIV32: sys_tc = SAC_TC_DIV32;
      SAC_CLK_DIV64: sys_tc = SAC_TC_DIV64;
      default:       sys_tc = SAC_TC_DIV8;
    endcase
  end

  assign sys_hit = (sys_cnt_reg == sys_tc);
  assign rc_hit  = osc_tick && (rc_cnt_reg == SAC_TC_RC);

  // system clock divider, follows core_clk
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_cnt_reg <= 6'h00;
    end else if (tk.restart || sys_hit) begin
      sys_cnt_reg <= 6'h00;
    end else begin
      sys_cnt_reg <= sys_cnt_reg + 6'h01;
    end
  end

  // rc divider counts oscillator pulses only
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rc_cnt_reg <= 4'h0;
    end else if (tk.restart) begin
      rc_cnt_reg <= 4'h0;
    end else if (osc_tick) begin
      rc_cnt_reg <= rc_cnt_reg + 4'h1;
    end
  end

  // registered bit period tick from the selected source
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_reg <= 1'b0;
    end else if (tk.restart) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= use_rc ? rc_hit : sys_hit;
    end
  end

  assign tk.tick = tick_reg;

endmodule

// ===== tb/sac_analog_model.sv
`timescale 1ns/1ns
module sac_analog_model
  import sac_pkg::*;
#(
  parameter int OSC_DIV = 3  // core cycles per oscillator pulse
) (
  input  wire logic       core_clk,      // system clock
  input  wire logic       rst_b,         // async reset, active low
  input  wire logic [9:0] ch_level [32], // level seen on each source
  input  wire logic [4:0] mux_select,    // source in use
  input  wire logic       mux_valid,     // source exists
  input  wire logic       hold_en,       // hold stage isolated
  input  wire logic [9:0] dac_code,      // trial code
  output logic            cmp_above,     // held level at or above trial
  output logic            osc_tick       // oscillator pulse
);
  logic [9:0] held_reg;
  logic [9:0] live;
  logic       flip_reg;
  int         osc_cnt;
  // a reserved code reaches no source, so the level wanders every cycle
  assign live = mux_valid ? ch_level[mux_select] : {5{flip_reg, ~flip_reg}};
  // one hold stage behind the mux follows the live source until it holds
  assign cmp_above = (hold_en ? held_reg : live) >= dac_code;
  // track, hold and oscillator pulses
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      held_reg <= 10'h000;
      flip_reg <= 1'b0;
      osc_cnt  <= 0;
      osc_tick <= 1'b0;
    end else begin
      if (!hold_en) begin
        held_reg <= live;
      end
      flip_reg <= ~flip_reg;
      osc_cnt  <= (osc_cnt == OSC_DIV - 1) ? 0 : osc_cnt + 1;
      osc_tick <= (osc_cnt == OSC_DIV - 1);
    end
  end
endmodule

// ===== tb/test_sar_adc_control.sv
`timescale 1ns/1ns
module test_sar_adc_control
  import sac_pkg::*;
;
  localparam int OSC_DIV = 3;
  localparam int TAD_TAB[8] = '{8, 8, 32, 16 * OSC_DIV, 8, 16, 64, 16 * OSC_DIV};
  logic        core_clk;
  logic        rst_b;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc_tick;
  logic        cmp_above;
  logic [4:0]  mux_select;
  logic        mux_valid;
  logic        hold_en;
  logic [9:0]  dac_code;
  logic        adc_irq;
  logic [9:0]  ch_level [32];
  logic [31:0] rd;
  logic        err;
  logic        ok;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cycles = 0;
  int          dur;
  int          n;

  sac_adc_ctrl #(.LARGE_VARIANT(1'b1)) u_sac_adc_ctrl (
    .core_clk(core_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_tick(osc_tick), .cmp_above(cmp_above), .mux_select(mux_select),
    .mux_valid(mux_valid), .hold_en(hold_en), .dac_code(dac_code), .adc_irq(adc_irq));

  sac_analog_model #(.OSC_DIV(OSC_DIV)) u_sac_analog_model (
    .core_clk(core_clk), .rst_b(rst_b), .ch_level(ch_level), .mux_select(mux_select),
    .mux_valid(mux_valid), .hold_en(hold_en), .dac_code(dac_code),
    .cmp_above(cmp_above), .osc_tick(osc_tick));

  // free running core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1); // only the hang guard ends a stuck wait
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // waits for the hold window to open, then counts its cycles
  task automatic finish_conv;
    int g;
    g = 0;
    dur = 0;
    while (hold_en !== 1'b1 && g < 20) begin
      @(posedge core_clk);
      g++;
    end
    while (hold_en === 1'b1 && dur < 3000) begin
      @(posedge core_clk);
      dur++;
    end
    @(posedge core_clk); // let the completion edge land before looking
  endtask

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    for (int i = 0; i < 32; i++) ch_level[i] = 10'(i * 29 + 17); // analog pins
    ch_level[0] = 10'h000;
    ch_level[3] = 10'h2a5;
    ch_level[4] = 10'h3ff;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    // reset values and an unmapped place
    rchk(SAC_OFS_CTRL_FIRST, {24'h0, SAC_CTRL_FIRST_RST});
    rchk(SAC_OFS_CTRL_SECOND, {24'h0, SAC_CTRL_SECOND_RST});
    rchk(SAC_OFS_RESULT_HIGH, 32'h0);
    rchk(SAC_OFS_INT_STATUS, 32'h0);
    rchk(8'h18, 32'h0);
    check({31'h0, err}, 32'h1);
    // trigger with the converter unpowered is refused
    apb(1'b1, SAC_OFS_CTRL_FIRST, 32'h2);
    repeat (4) @(posedge core_clk);
    check({31'h0, hold_en}, 32'h0);
    rchk(SAC_OFS_CTRL_FIRST, 32'h0);
    // every channel code reaches the mux
    for (int c = 0; c < 32; c++) begin
      apb(1'b1, SAC_OFS_CTRL_FIRST, 32'(c) << SAC_CHS_LSB);
      @(posedge core_clk);
      check({27'h0, mux_select}, 32'(c));
      check({31'h0, mux_valid}, 32'(!(c == SAC_CH_RSVD_A || c == SAC_CH_RSVD_B
                                      || c > SAC_CH_LAST)));
    end
    // one conversion per clock select code, mask alternating
    for (int s = 0; s < 8; s++) begin
      n = TAD_TAB[s];
      apb(1'b1, SAC_OFS_INT_MASK, 32'(s % 2));
      apb(1'b1, SAC_OFS_CTRL_SECOND, 32'(s) << SAC_CLKSEL_LSB);
      apb(1'b1, SAC_OFS_CTRL_FIRST, (32'(s) << SAC_CHS_LSB) | 32'h1);
      repeat (10) @(posedge core_clk); // acquisition delay
      apb(1'b1, SAC_OFS_CTRL_FIRST, (32'(s) << SAC_CHS_LSB) | 32'h3);
      finish_conv();
      ok = (s % 4 == 3) ? (dur >= 10 * n && dur <= 12 * n)
                        : (dur >= 11 * n - 1 && dur <= 11 * n + 3);
      check({31'h0, ok}, 32'h1);
      check({31'h0, adc_irq}, 32'(s % 2));
      rchk(SAC_OFS_CTRL_FIRST, (32'(s) << SAC_CHS_LSB) | 32'h1);
      rchk(SAC_OFS_INT_STATUS, 32'h1);
      @(posedge core_clk);
      check({31'h0, adc_irq}, 32'h0);
      rchk(SAC_OFS_INT_STATUS, 32'h0);
      rchk(SAC_OFS_RESULT_LOW, {24'h0, ch_level[s][7:0]});
      rchk(SAC_OFS_RESULT_HIGH, {30'h0, ch_level[s][9:8]});
    end
    // abort mid-conversion keeps the old result and sets no flag
    apb(1'b1, SAC_OFS_CTRL_SECOND, 32'(SAC_CLK_DIV16) << SAC_CLKSEL_LSB);
    apb(1'b1, SAC_OFS_CTRL_FIRST, 32'h0d);
    repeat (10) @(posedge core_clk);
    apb(1'b1, SAC_OFS_CTRL_FIRST, 32'h0f);
    repeat (40) @(posedge core_clk);
    apb(1'b1, SAC_OFS_CTRL_FIRST, 32'h0d);
    repeat (40) @(posedge core_clk);
    rchk(SAC_OFS_INT_STATUS, 32'h0);
    rchk(SAC_OFS_RESULT_LOW, {24'h0, ch_level[7][7:0]});
    // channel switch mid-conversion: mux moves at once, held sample converts
    apb(1'b1, SAC_OFS_CTRL_FIRST, 32'h11);
    repeat (10) @(posedge core_clk);
    apb(1'b1, SAC_OFS_CTRL_FIRST, 32'h13);
    repeat (30) @(posedge core_clk);
    apb(1'b1, SAC_OFS_CTRL_FIRST, 32'h07);
    @(posedge core_clk);
    check({27'h0, mux_select}, 32'h1);
    check({31'h0, hold_en}, 32'h1);
    finish_conv();
    rchk(SAC_OFS_RESULT_LOW, 32'hff);
    rchk(SAC_OFS_RESULT_HIGH, 32'h3);
    rchk(SAC_OFS_INT_STATUS, 32'h1);
    // writes to the result are ignored
    apb(1'b1, SAC_OFS_RESULT_LOW, 32'haa);
    rchk(SAC_OFS_RESULT_LOW, 32'hff);
    // a reserved channel converts without disturbing the setup
    apb(1'b1, SAC_OFS_CTRL_FIRST, (32'(SAC_CH_RSVD_A) << SAC_CHS_LSB) | 32'h3);
    finish_conv();
    rchk(SAC_OFS_CTRL_SECOND, 32'(SAC_CLK_DIV16) << SAC_CLKSEL_LSB);
    rchk(SAC_OFS_INT_STATUS, 32'h1);
    final_report();
  end
endmodule
